// ===== core/hsgg_pkg.sv
package hsgg_pkg;

    // Register offsets
    localparam logic [7:0]  ADDR_GUARD      = 8'h09;
    localparam logic [7:0]  ADDR_TH_ONE     = 8'h0A;
    localparam logic [7:0]  ADDR_TH_TWO     = 8'h0B;
    localparam logic [7:0]  ADDR_CTRL       = 8'h0C;
    localparam logic [7:0]  ADDR_SEQ_FIRST  = 8'h0F;
    localparam logic [7:0]  ADDR_SEQ_LAST   = 8'h16;

    // Values after reset
    localparam logic [7:0]  RST_GUARD       = 8'h00;
    localparam logic [7:0]  RST_TH_ONE      = 8'h92;
    localparam logic [7:0]  RST_TH_TWO      = 8'h8D;
    localparam logic [7:0]  RST_CTRL        = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

    // Field positions
    localparam int          GUARD_EN_HI     = 7;
    localparam int          GUARD_EN_LO     = 6;
    localparam int          CUTOFF_HI       = 2;
    localparam int          CUTOFF_LO       = 0;
    localparam int          GO_BIT          = 0;

    // Guard level enable codes
    localparam logic [1:0]  GUARD_OFF       = 2'h0;
    localparam logic [1:0]  GUARD_ONE       = 2'h1;
    localparam logic [1:0]  GUARD_BOTH      = 2'h2;

    // Undervoltage cutoff decode, millivolts
    localparam logic [11:0] CUTOFF_BASE_MV  = 12'h09C4;
    localparam logic [11:0] CUTOFF_STEP_MV  = 12'h0064;

    // Pin synchroniser depth and width
    localparam int          SYNC_STAGES     = 3;
    localparam int          SYNC_W          = 21;

    typedef enum logic [1:0] {
        MODE_RTP  = 2'h0,
        MODE_SEQ  = 2'h1,
        MODE_DIAG = 2'h2,
        MODE_CAL  = 2'h3
    } hsgg_mode_t;

    typedef enum logic [1:0] {
        LIMIT_NONE = 2'h0,
        LIMIT_ONE  = 2'h1,
        LIMIT_TWO  = 2'h2
    } hsgg_limit_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_STBY = 3'b100
    } hsgg_state_t;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       seq_play;
        hsgg_mode_t kind;
    } hsgg_cmd_t;

endpackage

// ===== core/hsgg_sync.sv
module hsgg_sync
    import hsgg_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage_ff;
            logic                   out_ff;
            logic                   nxt_out;

            // Change accepted once the second and third stages agree
            always_comb begin
                nxt_out = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : out_ff;
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage_ff <= '0;
                    out_ff   <= 1'b0;
                end else begin
                    stage_ff <= {stage_ff[SYNC_STAGES-2:0], d_in[i]};
                    out_ff   <= nxt_out;
                end
            end

            assign d_out[i] = out_ff;
        end
    endgenerate

endmodule

// ===== core/hsgg_supply_guard.sv
module hsgg_supply_guard
    import hsgg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        sample,
    input  wire logic [1:0]  level_en,
    input  wire logic [7:0]  th_one,
    input  wire logic [7:0]  th_two,
    input  wire logic [7:0]  vdd_lvl,
    // Result
    output hsgg_limit_t      limit
);

    hsgg_limit_t limit_ff;
    hsgg_limit_t nxt_limit;

    // Supply is looked at only when an effect starts
    always_comb begin
        nxt_limit = limit_ff;
        if (sample) begin
            nxt_limit = LIMIT_NONE;
            if ((level_en == GUARD_BOTH) && (vdd_lvl < th_two)) begin
                nxt_limit = LIMIT_TWO;
            end else if (((level_en == GUARD_ONE) || (level_en == GUARD_BOTH)) && (vdd_lvl < th_one)) begin
                nxt_limit = LIMIT_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            limit_ff <= LIMIT_NONE;
        end else begin
            limit_ff <= nxt_limit;
        end
    end

    assign limit = limit_ff;

    property p_limit_hold;
        @(posedge clk) disable iff (rst) !sample |=> $stable(limit);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("Limit moved without a sample");

    property p_limit_two;
        @(posedge clk) disable iff (rst) sample && level_en == GUARD_BOTH && vdd_lvl < th_two |=> limit == LIMIT_TWO;
    endproperty
    a_limit_two: assert property (p_limit_two) else $error("Second limit not chosen");

    property p_limit_one;
        @(posedge clk) disable iff (rst)
            sample && level_en == GUARD_ONE && vdd_lvl < th_one |=> limit == LIMIT_ONE;
    endproperty
    a_limit_one: assert property (p_limit_one) else $error("First limit not chosen");

    property p_limit_off;
        @(posedge clk) disable iff (rst) sample && level_en == GUARD_OFF |=> limit == LIMIT_NONE;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("Limit applied with guard off");

endmodule

// ===== core/hsgg_ctrl.sv
// Notes on behaviour
// - Bits 7-6 of the guard register enable the supply guard: 0 off, 1 first level only, 2 both levels.
// - Bits 2-0 of the guard register pick an undervoltage cutoff of 2.5 V plus 0.1 V per code step.
// - Supply below the selected cutoff turns the output stage off at once and enters standby.
// - An eight-bit first threshold, reset 146, applies the first overdrive limit when supply is below it.
// - An eight-bit second threshold, reset 141, applies the second overdrive limit when supply is below it.
// - Supply is compared only at the start of an effect and the chosen limit holds for that effect.
// - Setting the go bit, bit 0 at process_launch_control, starts the process that the mode selects.
// - In sequencer mode the go bit starts playback of the slots at 0x0F through 0x16 as a software trigger.
// - The go bit reads one while the process runs and clears itself when it completes.
// - Clearing the go bit during playback aborts the running process at once.
// - An external trigger sets the go bit and launches the process as a host write of one would.
// - The go bit can launch sequencer playback, calibration or diagnostics as chosen by mode.
module hsgg_ctrl
    import hsgg_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Register port from the serial control interface
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // Supply monitor and trigger pins
    input  wire logic [11:0] VDD_MV,
    input  wire logic [7:0]  VDD_LVL,
    input  wire logic        EXT_TRIG,
    // Playback engine
    input  hsgg_mode_t       MODE,
    input  wire logic        PROC_DONE,
    output hsgg_cmd_t        PROC_CMD,
    output hsgg_limit_t      OD_LIMIT,
    // Power state
    output logic             OUT_STAGE_EN,
    output logic             STANDBY
);

    // Synchronised pins
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s;
    logic [11:0]       vdd_mv_s;
    logic [7:0]        vdd_lvl_s;
    logic              trig_s;

    assign pin_raw = {EXT_TRIG, VDD_LVL, VDD_MV};
    assign vdd_mv_s  = pin_s[11:0];
    assign vdd_lvl_s = pin_s[19:12];
    assign trig_s    = pin_s[20];

    hsgg_sync #(.W(SYNC_W)) u_sync (
        .clk   (CLK),
        .rst   (SYS_RST),
        .d_in  (pin_raw),
        .d_out (pin_s)
    );

    // Register storage
    logic [7:0]  guard_ff;
    logic [7:0]  th_one_ff;
    logic [7:0]  th_two_ff;
    logic [7:1]  ctrl_rsv_ff;
    logic [7:0]  rdata_ff;
    logic        trig_q_ff;
    logic [7:0]  nxt_guard;
    logic [7:0]  nxt_th_one;
    logic [7:0]  nxt_th_two;
    logic [7:1]  nxt_ctrl_rsv;
    logic [7:0]  nxt_rdata;

    // Process control
    hsgg_state_t state_ff;
    hsgg_state_t nxt_state;
    hsgg_cmd_t   cmd_ff;
    hsgg_cmd_t   nxt_cmd;
    logic        out_en_ff;
    logic        nxt_out_en;

    // Decoded events
    logic        wr_ctrl;
    logic        go_wr_one;
    logic        go_wr_zero;
    logic        trig_rise;
    logic        launch;
    logic        go_bit;
    logic [11:0] cutoff_mv;
    logic        under_volt;

    assign wr_ctrl    = REG_WR && (REG_ADDR == ADDR_CTRL);
    assign go_wr_one  = wr_ctrl && REG_WDATA[GO_BIT];
    assign go_wr_zero = wr_ctrl && !REG_WDATA[GO_BIT];
    assign trig_rise  = trig_s && !trig_q_ff;
    assign launch     = go_wr_one || trig_rise;
    assign go_bit     = (state_ff == ST_RUN);

    // Cutoff in millivolts from the three-bit select
    assign cutoff_mv  = CUTOFF_BASE_MV
                      + 12'(CUTOFF_STEP_MV * {9'h000, guard_ff[CUTOFF_HI:CUTOFF_LO]});
    assign under_volt = (vdd_mv_s < cutoff_mv);

    // Register writes and read data
    always_comb begin
        nxt_guard    = guard_ff;
        nxt_th_one   = th_one_ff;
        nxt_th_two   = th_two_ff;
        nxt_ctrl_rsv = ctrl_rsv_ff;
        nxt_rdata    = rdata_ff;
        if (REG_WR) begin
            case (REG_ADDR)
                ADDR_GUARD:  nxt_guard    = REG_WDATA;
                ADDR_TH_ONE: nxt_th_one   = REG_WDATA;
                ADDR_TH_TWO: nxt_th_two   = REG_WDATA;
                ADDR_CTRL:   nxt_ctrl_rsv = REG_WDATA[7:1];
                default:     nxt_guard    = guard_ff;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_GUARD:  nxt_rdata = guard_ff;
                ADDR_TH_ONE: nxt_rdata = th_one_ff;
                ADDR_TH_TWO: nxt_rdata = th_two_ff;
                ADDR_CTRL:   nxt_rdata = {ctrl_rsv_ff, go_bit};
                default:     nxt_rdata = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            guard_ff    <= RST_GUARD;
            th_one_ff   <= RST_TH_ONE;
            th_two_ff   <= RST_TH_TWO;
            ctrl_rsv_ff <= RST_CTRL[7:1];
            rdata_ff    <= RD_UNMAPPED;
            trig_q_ff   <= 1'b0;
        end else begin
            guard_ff    <= nxt_guard;
            th_one_ff   <= nxt_th_one;
            th_two_ff   <= nxt_th_two;
            ctrl_rsv_ff <= nxt_ctrl_rsv;
            rdata_ff    <= nxt_rdata;
            trig_q_ff   <= trig_s;
        end
    end

    // Process sequencing; undervoltage outranks every request
    always_comb begin
        nxt_state  = state_ff;
        nxt_cmd    = '{start: 1'b0, abort: 1'b0, seq_play: 1'b0, kind: cmd_ff.kind};
        nxt_out_en = out_en_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_out_en = 1'b0;
                if (under_volt) begin
                    nxt_state = ST_STBY;
                end else if (launch) begin
                    nxt_state        = ST_RUN;
                    nxt_cmd.start    = 1'b1;
                    nxt_cmd.kind     = MODE;
                    nxt_cmd.seq_play = (MODE == MODE_SEQ);
                    nxt_out_en       = 1'b1;
                end
            end
            ST_RUN: begin
                // A second launch is ignored here, so the effect runs on untouched
                if (under_volt) begin
                    nxt_state     = ST_STBY;
                    nxt_cmd.abort = 1'b1;
                    nxt_out_en    = 1'b0;
                end else if (go_wr_zero) begin
                    nxt_state     = ST_IDLE;
                    nxt_cmd.abort = 1'b1;
                    nxt_out_en    = 1'b0;
                end else if (PROC_DONE) begin
                    nxt_state  = ST_IDLE;
                    nxt_out_en = 1'b0;
                end
            end
            ST_STBY: begin
                nxt_out_en = 1'b0;
                if (!under_volt) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state  = ST_IDLE;
                nxt_out_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff  <= ST_IDLE;
            cmd_ff    <= '{start: 1'b0, abort: 1'b0, seq_play: 1'b0, kind: MODE_RTP};
            out_en_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cmd_ff    <= nxt_cmd;
            out_en_ff <= nxt_out_en;
        end
    end

    // Overdrive limit captured on each start
    hsgg_supply_guard u_guard (
        .clk      (CLK),
        .rst      (SYS_RST),
        .sample   (nxt_cmd.start),
        .level_en (guard_ff[GUARD_EN_HI:GUARD_EN_LO]),
        .th_one   (th_one_ff),
        .th_two   (th_two_ff),
        .vdd_lvl  (vdd_lvl_s),
        .limit    (OD_LIMIT)
    );

    assign REG_RDATA    = rdata_ff;
    assign PROC_CMD     = cmd_ff;
    assign OUT_STAGE_EN = out_en_ff;
    assign STANDBY      = (state_ff == ST_STBY);

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_go_start;
        state_ff == ST_IDLE && !under_volt && go_wr_one |=> go_bit && PROC_CMD.start && OUT_STAGE_EN;
    endproperty
    a_go_start: assert property (p_go_start) else $error("Go write did not start a process");

    property p_kind;
        state_ff == ST_IDLE && !under_volt && launch |=> PROC_CMD.kind == $past(MODE);
    endproperty
    a_kind: assert property (p_kind) else $error("Launched kind differs from mode");

    property p_seq;
        PROC_CMD.start |-> PROC_CMD.seq_play == (PROC_CMD.kind == MODE_SEQ);
    endproperty
    a_seq: assert property (p_seq) else $error("Sequencer playback flag wrong");

    property p_hold;
        go_bit && !under_volt && !go_wr_zero && !PROC_DONE |=> go_bit && !PROC_CMD.abort;
    endproperty
    a_hold: assert property (p_hold) else $error("Go bit dropped while running");

    property p_done;
        go_bit && !under_volt && !go_wr_zero && PROC_DONE |=> !go_bit && !PROC_CMD.abort && !OUT_STAGE_EN;
    endproperty
    a_done: assert property (p_done) else $error("Go bit not cleared on completion");

    property p_abort;
        go_bit && !under_volt && go_wr_zero |=> PROC_CMD.abort && !go_bit && !OUT_STAGE_EN;
    endproperty
    a_abort: assert property (p_abort) else $error("Clearing go did not abort");

    property p_trig;
        state_ff == ST_IDLE && !under_volt && trig_rise |=> go_bit && PROC_CMD.start;
    endproperty
    a_trig: assert property (p_trig) else $error("Trigger did not launch");

    property p_rewrite;
        go_bit && go_wr_one && !PROC_DONE && !under_volt |=> go_bit && !PROC_CMD.start && $stable(PROC_CMD.kind);
    endproperty
    a_rewrite: assert property (p_rewrite) else $error("Go rewrite disturbed the process");

    property p_undervoltage_lockout;
        under_volt |=> STANDBY && !OUT_STAGE_EN && !go_bit;
    endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("Undervoltage did not force standby");

    property p_cutoff_top;
        guard_ff[CUTOFF_HI:CUTOFF_LO] == 3'h7 |-> (under_volt == (vdd_mv_s < 12'h0C80));
    endproperty
    a_cutoff_top: assert property (p_cutoff_top) else $error("Top cutoff is not 3.2 V");

    property p_rd_unmapped;
        REG_RD && (REG_ADDR < ADDR_GUARD || REG_ADDR > ADDR_CTRL) |=> REG_RDATA == RD_UNMAPPED;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read not zero");

    property p_go_read;
        REG_RD && REG_ADDR == ADDR_CTRL |=> REG_RDATA[GO_BIT] == $past(go_bit);
    endproperty
    a_go_read: assert property (p_go_read) else $error("Go bit reads wrong");

    property p_guard_write;
        REG_WR && REG_ADDR == ADDR_GUARD |=> guard_ff == $past(REG_WDATA);
    endproperty
    a_guard_write: assert property (p_guard_write) else $error("Guard write lost");

    property p_stby_refuse;
        STANDBY |=> !PROC_CMD.start;
    endproperty
    a_stby_refuse: assert property (p_stby_refuse) else $error("Launch taken in standby");

    property p_stage_off;
        STANDBY |-> !OUT_STAGE_EN;
    endproperty
    a_stage_off: assert property (p_stage_off) else $error("Output stage on in standby");

    property p_abort_idle;
        PROC_CMD.abort |-> !go_bit && !OUT_STAGE_EN;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("Process still running after abort");

endmodule

// ===== verification/hsgg_engine_model.sv
module hsgg_engine_model
    import hsgg_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Command side
    input  hsgg_cmd_t       cmd,
    input  wire logic [7:0] dly,
    // Completion
    output logic            done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_ff;
    logic       busy_ff;

    // Abort wins over a late completion so a cancelled effect never reports done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            cnt_ff  <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (cmd.abort) begin
                busy_ff <= 1'b0;
            end else if (cmd.start) begin
                busy_ff <= 1'b1;
                cnt_ff  <= dly;
            end else if (busy_ff && cnt_ff == 8'h00) begin
                busy_ff <= 1'b0;
                done    <= 1'b1;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

// ===== verification/haptic_supply_guard_and_go_control_tb.sv
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module haptic_supply_guard_and_go_control_tb
    import hsgg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [11:0] vdd_mv;
    logic [7:0]  vdd_lvl;
    logic        ext_trig;
    hsgg_mode_t  mode;
    logic        proc_done;
    hsgg_cmd_t   proc_cmd;
    hsgg_limit_t od_limit;
    logic        out_stage_en;
    logic        standby;
    logic [7:0]  eng_dly;
    int          failures;
    int          n_checks;
    int          n_start;
    int          n_abort;
    int          cycles;
    int          seed;
    logic        start_seq;
    hsgg_mode_t  start_kind;

    hsgg_ctrl uut (
        .CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .VDD_MV(vdd_mv),
        .VDD_LVL(vdd_lvl), .EXT_TRIG(ext_trig), .MODE(mode), .PROC_DONE(proc_done),
        .PROC_CMD(proc_cmd), .OD_LIMIT(od_limit), .OUT_STAGE_EN(out_stage_en), .STANDBY(standby)
    );

    hsgg_engine_model engine (
        .clk(clk), .rst(sys_rst), .cmd(proc_cmd), .dly(eng_dly), .done(proc_done)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pulse monitor: command outputs stand one cycle, so they are caught at the next edge
    always @(posedge clk) begin
        cycles++;
        if (proc_cmd.start === 1'b1) begin
            n_start++;
            start_seq  = proc_cmd.seq_play;
            start_kind = proc_cmd.kind;
        end
        if (proc_cmd.abort === 1'b1) begin
            n_abort++;
        end
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    function automatic hsgg_limit_t exp_limit(logic [1:0] en, logic [7:0] t1, logic [7:0] t2, logic [7:0] lv);
        if (en == GUARD_BOTH && lv < t2) return LIMIT_TWO;
        if ((en == GUARD_ONE || en == GUARD_BOTH) && lv < t1) return LIMIT_ONE;
        return LIMIT_NONE;
    endfunction

    // Strobes stay up after a transfer so back-to-back calls never lower and raise one in a time step
    task automatic tick(input int n);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd    = 1'b0;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        reg_wr   = 1'b0;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic wait_start(input int lim);
        int  s0;
        bit  seen;
        s0   = n_start;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            tick(1);
            seen = (n_start != s0);
        end
        `CHK(seen, 1'b1)
    endtask

    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && out_stage_en !== 1'b0; i++) begin
            tick(1);
        end
        `CHK(out_stage_en, 1'b0)
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        logic [7:0]  v;
        logic [7:0]  t1;
        logic [7:0]  t2;
        logic [7:0]  lv;
        logic [1:0]  en;
        logic [11:0] cut;
        hsgg_limit_t lim;
        int          s;
        int          a;
        seed = 32'hb570;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vdd_mv = 12'h0CE4;
        vdd_lvl = 8'hFF;
        ext_trig = 1'b0;
        mode = MODE_SEQ;
        eng_dly = 8'h05;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        tick(8);

        rdc(ADDR_GUARD, RST_GUARD);
        rdc(ADDR_TH_ONE, RST_TH_ONE);
        rdc(ADDR_TH_TWO, RST_TH_TWO);
        rdc(ADDR_CTRL, RST_CTRL);
        rdc(8'h20, RD_UNMAPPED);
        for (int k = 0; k < 3; k++) begin
            v = 8'($random(seed));
            wr(ADDR_GUARD + k[7:0], v);
            rdc(ADDR_GUARD + k[7:0], v);
        end
        wr(ADDR_CTRL, 8'hFE);
        rdc(ADDR_CTRL, 8'hFE);
        $display("test registers done");

        for (int k = 0; k < 4; k++) begin
            mode = hsgg_mode_t'(k[1:0]);
            wr(ADDR_CTRL, 8'h01);
            wait_start(4);
            `CHK(start_seq, mode == MODE_SEQ)
            `CHK(start_kind, mode)
            rdc(ADDR_CTRL, 8'h01);
            wait_idle(30);
            rdc(ADDR_CTRL, 8'h00);
        end
        $display("test modes done");

        mode = MODE_SEQ;
        for (int i = 0; i < 12; i++) begin
            en = 2'($random(seed));
            t1 = 8'($random(seed)) | 8'h01;
            t2 = 8'($random(seed)) % t1;
            lv = 8'($random(seed));
            if (i == 2) begin
                en = GUARD_BOTH;
                t1 = RST_TH_ONE;
                t2 = RST_TH_TWO;
                lv = RST_TH_TWO - 8'h01;
            end
            if (i == 3) begin
                en = GUARD_OFF;
                lv = 8'h00;
            end
            if (i == 0) begin
                en = GUARD_BOTH;
                lv = t2;
            end
            if (i == 1) begin
                en = GUARD_ONE;
                lv = t1 - 8'h01;
            end
            wr(ADDR_GUARD, {en, 6'h00});
            wr(ADDR_TH_ONE, t1);
            wr(ADDR_TH_TWO, t2);
            vdd_lvl = lv;
            tick(6);
            lim = exp_limit(en, t1, t2, lv);
            wr(ADDR_CTRL, 8'h01);
            wait_start(4);
            `CHK(od_limit, lim)
            vdd_lvl = ~lv;
            tick(6);
            `CHK(od_limit, lim)
            wait_idle(30);
        end
        $display("test limits done");

        eng_dly = 8'h3C;
        wr(ADDR_CTRL, 8'h01);
        wait_start(4);
        s = n_start;
        tick(3);
        wr(ADDR_CTRL, 8'h01);
        tick(3);
        `CHK(n_start, s)
        `CHK(out_stage_en, 1'b1)
        a = n_abort;
        wr(ADDR_CTRL, 8'h00);
        tick(2);
        `CHK(n_abort, a + 1)
        `CHK(out_stage_en, 1'b0)
        rdc(ADDR_CTRL, 8'h00);
        $display("test abort done");

        eng_dly = 8'h05;
        ext_trig = 1'b1;
        wait_start(10);
        ext_trig = 1'b0;
        rdc(ADDR_CTRL, 8'h01);
        wait_idle(30);
        $display("test trigger done");

        for (int k = 0; k < 8; k++) begin
            cut = CUTOFF_BASE_MV + CUTOFF_STEP_MV * k[11:0];
            wr(ADDR_GUARD, {5'h00, k[2:0]});
            vdd_mv = cut;
            tick(7);
            `CHK(standby, 1'b0)
            vdd_mv = cut - 12'h001;
            tick(7);
            `CHK(standby, 1'b1)
            s = n_start;
            wr(ADDR_CTRL, 8'h01);
            tick(3);
            `CHK(n_start, s)
            vdd_mv = 12'h0CE4;
            tick(7);
        end
        eng_dly = 8'h3C;
        wr(ADDR_CTRL, 8'h01);
        wait_start(4);
        a = n_abort;
        vdd_mv = cut - 12'h001;
        tick(7);
        `CHK(out_stage_en, 1'b0)
        `CHK(standby, 1'b1)
        `CHK(n_abort, a + 1)
        $display("test undervoltage done");
        conclude();
    end
endmodule
